// [core/pcs_defs.svh]
/*
 Offsets, field positions, reset values and timing counts for the clock
 status and profiling counter block. Included by the design files only.
*/
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// Register byte offsets
`define PCS_OFF_PLL0_PLL1_OBSERVE_CLOCK_ENABLE      8'h00
`define PCS_OFF_PLL1_PLL1_OBSERVE_CLOCK_ENABLE      8'h04
`define PCS_OFF_PLL0_PLL0_CLOCK_RUN_STATUS    8'h08
`define PCS_OFF_PLL1_PLL0_CLOCK_RUN_STATUS    8'h0C
`define PCS_OFF_PLL0_SYSSTAT   8'h10
`define PCS_OFF_PLL1_SYSSTAT   8'h14
`define PCS_OFF_PLL0_OSCILLATOR_DIVIDER_REGISTER    8'h18
`define PCS_OFF_PLL1_OSCILLATOR_DIVIDER_REGISTER    8'h1C
`define PCS_OFF_PLL0_DIVEN     8'h20
`define PCS_OFF_PLL1_DIVEN     8'h24
`define PCS_OFF_CNT_LOW        8'h28
`define PCS_OFF_CNT_HIGH       8'h2C

// Field positions
`define PCS_BIT_AUX_EN         0
`define PCS_BIT_OBS_EN         1
`define PCS_BIT_OD1_EN         15

// Reset values
`define PCS_RST_PLL0_AUX_EN    1'b1
`define PCS_RST_PLL0_OBS_EN    1'b1
`define PCS_RST_PLL1_OBS_EN    1'b0
`define PCS_RST_OD1_EN         1'b1
`define PCS_RST_DIV_EN         1'b1

// Divided system clock counts
`define PCS_PLL0_SYSCLKS       7
`define PCS_PLL1_SYSCLKS       3

// Counter prescale: one count per this many system clocks
`define PCS_CNT_PRESCALE       4

`endif

// [core/pcs_pkg.sv]
/*
 Types shared by the clock status block and its profiling counter.
 Assumes the defs header is compiled alongside.
*/
package pcs_pkg;

    // Register bus request bundle
    typedef struct packed {
        logic [7:0]  addr;   // Byte address
        logic [31:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } pcs_bus_req_t;

    // Profiling counter run state
    typedef enum logic {
        PCS_CNT_IDLE,
        PCS_CNT_RUN
    } pcs_cnt_state_t;

endpackage

// [core/pcs_profile_counter.sv]
/*
 Free-running 64-bit profiling counter with snapshot.
 Assumes start and snap are one-cycle pulses on the same clock and a
 synchronised reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"

module pcs_profile_counter #(
    parameter int WIDTH = 64                 // Counter width
) (
    input  wire logic             clk,       // System clock
    input  wire logic             rst_n,     // Synchronised reset, low active
    input  wire logic             start,     // Start pulse
    input  wire logic             snap,      // Snapshot pulse
    output var  logic [WIDTH-1:0] snapshot,  // Captured count
    output var  logic             running    // Counter started
);
    import pcs_pkg::*;

    localparam logic [1:0] PRESCALE_LAST = 2'(`PCS_CNT_PRESCALE - 1); // Last prescale step

    pcs_cnt_state_t   state;     // Run state
    logic [1:0]       prescale;  // Divide-by-four phase
    logic [WIDTH-1:0] count;     // Live count
    logic [WIDTH-1:0] held;      // Captured count between reads

    // Start once; no way back except reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PCS_CNT_IDLE;
        end else begin
            unique case (state)
                PCS_CNT_IDLE: begin
                    if (start) begin
                        state <= PCS_CNT_RUN;
                    end
                end
                PCS_CNT_RUN: begin
                    state <= PCS_CNT_RUN;
                end
            endcase
        end
    end

    // Prescaler and count; wraps naturally at all ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 2'h0;
            count    <= '0;
        end else if (state == PCS_CNT_RUN) begin
            if (prescale == PRESCALE_LAST) begin
                prescale <= 2'h0;
                count    <= count + 1'b1;
            end else begin
                prescale <= prescale + 2'h1;
            end
        end
    end

    // Capture both halves together so a low-then-high read pair matches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
        end else if (snap) begin
            held <= count;
        end
    end

    // The strobe cycle already shows the count being captured, so the low
    // read returns the very value that the following high read completes
    assign snapshot = snap ? count : held;

    // Running flag for status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
        end else begin
            running <= (state == PCS_CNT_RUN);
        end
    end

endmodule
`default_nettype wire

// [core/pcs_clock_status.sv]
/*
 Clock gating status registers for two PLL controllers plus the profiling
 counter, on a plain strobe register port.
 Assumes a single-cycle strobe master on sys_clk and an async reset pin.

*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"

module pcs_clock_status #(
    parameter int N0 = `PCS_PLL0_SYSCLKS,        // First controller sysclk count
    parameter int N1 = `PCS_PLL1_SYSCLKS         // Second controller sysclk count
) (
    input  wire logic                  sys_clk,  // System clock, 50 MHz
    input  wire logic                  arst_n,   // Async reset, low active
    input  wire pcs_pkg::pcs_bus_req_t bus_req,  // Register request
    output var  logic [31:0]           rdata,    // Read data, cycle after strobe
    output var  logic                  pll0_observe_clock_on, // First observe clock gate
    output var  logic                  pll0_aux_clock_on,     // Auxiliary clock gate
    output var  logic                  pll1_observe_clock_on, // Second observe clock gate
    output var  logic [N0-1:0]         pll0_sysclk_on,        // First controller sysclk gates
    output var  logic [N1-1:0]         pll1_sysclk_on         // Second controller sysclk gates
);
    import pcs_pkg::*;

    logic          rst_sync1;          // Reset release stage one
    logic          rst_n;              // Synchronised reset
    logic          pll0_obs_en;        // First observe enable
    logic          pll0_aux_en;        // First aux enable
    logic          pll1_obs_en;        // Second observe enable
    logic          pll0_od1_en;        // First oscillator divider enable
    logic          pll1_od1_en;        // Second oscillator divider enable
    logic [N0-1:0] pll0_div_en;        // First sysclk divider enables
    logic [N1-1:0] pll1_div_en;        // Second sysclk divider enables
    logic [63:0]   snapshot;           // Counter snapshot
    logic          cnt_running;        // Counter started, unused in map
    logic          wr_hit_low;         // Write to counter low word
    logic          rd_hit_low;         // Read of counter low word
    logic [31:0]   next_rdata;         // Read mux result

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    assign wr_hit_low = bus_req.wr && (bus_req.addr == `PCS_OFF_CNT_LOW);
    assign rd_hit_low = bus_req.rd && (bus_req.addr == `PCS_OFF_CNT_LOW);

    // Enable registers written by software
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll0_aux_en <= `PCS_RST_PLL0_AUX_EN;
            pll0_obs_en <= `PCS_RST_PLL0_OBS_EN;
            pll1_obs_en <= `PCS_RST_PLL1_OBS_EN;
            pll0_od1_en <= `PCS_RST_OD1_EN;
            pll1_od1_en <= `PCS_RST_OD1_EN;
            pll0_div_en <= {N0{`PCS_RST_DIV_EN}};
            pll1_div_en <= {N1{`PCS_RST_DIV_EN}};
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                `PCS_OFF_PLL0_PLL1_OBSERVE_CLOCK_ENABLE: begin
                    pll0_aux_en <= bus_req.wdata[`PCS_BIT_AUX_EN];
                    pll0_obs_en <= bus_req.wdata[`PCS_BIT_OBS_EN];
                end
                `PCS_OFF_PLL1_PLL1_OBSERVE_CLOCK_ENABLE: begin
                    pll1_obs_en <= bus_req.wdata[`PCS_BIT_OBS_EN];
                end
                `PCS_OFF_PLL0_OSCILLATOR_DIVIDER_REGISTER: begin
                    pll0_od1_en <= bus_req.wdata[`PCS_BIT_OD1_EN];
                end
                `PCS_OFF_PLL1_OSCILLATOR_DIVIDER_REGISTER: begin
                    pll1_od1_en <= bus_req.wdata[`PCS_BIT_OD1_EN];
                end
                `PCS_OFF_PLL0_DIVEN: begin
                    pll0_div_en <= bus_req.wdata[N0-1:0];
                end
                `PCS_OFF_PLL1_DIVEN: begin
                    pll1_div_en <= bus_req.wdata[N1-1:0];
                end
                default: begin
                    // Status, counter and unmapped writes store nothing
                end
            endcase
        end
    end

    // Clock gate outputs; status bits read these so they show the real state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll0_observe_clock_on <= 1'b0;
            pll0_aux_clock_on     <= 1'b0;
            pll1_observe_clock_on <= 1'b0;
            pll0_sysclk_on        <= '0;
            pll1_sysclk_on        <= '0;
        end else begin
            pll0_observe_clock_on <= pll0_obs_en & pll0_od1_en;
            pll0_aux_clock_on     <= pll0_aux_en;
            pll1_observe_clock_on <= pll1_obs_en & pll1_od1_en;
            pll0_sysclk_on        <= pll0_div_en;
            pll1_sysclk_on        <= pll1_div_en;
        end
    end

    // Read mux; reserved bits are zero
    always_comb begin
        next_rdata = 32'h0;
        unique case (bus_req.addr)
            `PCS_OFF_PLL0_PLL1_OBSERVE_CLOCK_ENABLE: begin
                next_rdata[`PCS_BIT_AUX_EN] = pll0_aux_en;
                next_rdata[`PCS_BIT_OBS_EN] = pll0_obs_en;
            end
            `PCS_OFF_PLL1_PLL1_OBSERVE_CLOCK_ENABLE: begin
                next_rdata[`PCS_BIT_OBS_EN] = pll1_obs_en;
            end
            `PCS_OFF_PLL0_PLL0_CLOCK_RUN_STATUS: begin
                next_rdata[`PCS_BIT_AUX_EN] = pll0_aux_clock_on;
                next_rdata[`PCS_BIT_OBS_EN] = pll0_observe_clock_on;
            end
            `PCS_OFF_PLL1_PLL0_CLOCK_RUN_STATUS: begin
                next_rdata[`PCS_BIT_OBS_EN] = pll1_observe_clock_on;
            end
            `PCS_OFF_PLL0_SYSSTAT: begin
                next_rdata[N0-1:0] = pll0_sysclk_on;
            end
            `PCS_OFF_PLL1_SYSSTAT: begin
                next_rdata[N1-1:0] = pll1_sysclk_on;
            end
            `PCS_OFF_PLL0_OSCILLATOR_DIVIDER_REGISTER: begin
                next_rdata[`PCS_BIT_OD1_EN] = pll0_od1_en;
            end
            `PCS_OFF_PLL1_OSCILLATOR_DIVIDER_REGISTER: begin
                next_rdata[`PCS_BIT_OD1_EN] = pll1_od1_en;
            end
            `PCS_OFF_PLL0_DIVEN: begin
                next_rdata[N0-1:0] = pll0_div_en;
            end
            `PCS_OFF_PLL1_DIVEN: begin
                next_rdata[N1-1:0] = pll1_div_en;
            end
            `PCS_OFF_CNT_LOW: begin
                // Low read returns the count captured by this same strobe
                next_rdata = snapshot[31:0];
            end
            `PCS_OFF_CNT_HIGH: begin
                next_rdata = snapshot[63:32];
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else if (bus_req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0;
        end
    end

    // Snapshot path shows the live count during the low read strobe and the
    // held copy afterwards, so both words of one read pair agree
    pcs_profile_counter #(
        .WIDTH (64)
    ) u_counter (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .start    (wr_hit_low),
        .snap     (rd_hit_low),
        .snapshot (snapshot),
        .running  (cnt_running)
    );

endmodule
`default_nettype wire

// [verification/pcs_clock_status_properties.sv]
/*
 Assertions on the clock status block, seen from its top ports only.
 Assumes the bench binds it to the top module; package compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_chk #(
    parameter int N0 = 7,  // First controller sysclks
    parameter int N1 = 3   // Second controller sysclks
) (
    input wire logic                  sys_clk,               // System clock
    input wire logic                  arst_n,                // Async reset
    input wire pcs_pkg::pcs_bus_req_t bus_req,               // Request
    input wire logic [31:0]           rdata,                 // Read data
    input wire logic                  pll0_observe_clock_on, // Gate
    input wire logic                  pll0_aux_clock_on,     // Gate
    input wire logic                  pll1_observe_clock_on, // Gate
    input wire logic [N0-1:0]         pll0_sysclk_on,        // Gates
    input wire logic [N1-1:0]         pll1_sysclk_on         // Gates
);
    import pcs_pkg::*;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Gates settle two edges after the write: enable, then status flop
    property p_pll1_obs_off;
        bus_req.wr && bus_req.addr == 8'h04 && !bus_req.wdata[1] |-> ##2 !pll1_observe_clock_on;
    endproperty
    a_pll1_obs_off: assert property (p_pll1_obs_off) else $error("second observe gate stayed on");

    // Divider off must stop the observe clock whatever its enable says
    property p_od1_off;
        bus_req.wr && bus_req.addr == 8'h1C && !bus_req.wdata[15] |-> ##2 !pll1_observe_clock_on;
    endproperty
    a_od1_off: assert property (p_od1_off) else $error("divider off left observe gate on");

    // Auxiliary gate follows the written enable bit
    property p_aux_follow;
        bus_req.wr && bus_req.addr == 8'h00 |-> ##2 pll0_aux_clock_on == $past(bus_req.wdata[0], 2);
    endproperty
    a_aux_follow: assert property (p_aux_follow) else $error("aux gate ignores its enable");

    property p_pll0_obs_off;
        bus_req.wr && bus_req.addr == 8'h00 && !bus_req.wdata[1] |-> ##2 !pll0_observe_clock_on;
    endproperty
    a_pll0_obs_off: assert property (p_pll0_obs_off) else $error("first observe gate stayed on");

    // Status reads must mirror the live gates, reserved bits zero
    property p_ck0_read;
        bus_req.rd && bus_req.addr == 8'h08 |=>
            rdata == {30'h0, $past(pll0_observe_clock_on), $past(pll0_aux_clock_on)};
    endproperty
    a_ck0_read: assert property (p_ck0_read) else $error("first status read wrong");

    property p_ck1_read;
        bus_req.rd && bus_req.addr == 8'h0C |=> rdata == {30'h0, $past(pll1_observe_clock_on), 1'h0};
    endproperty
    a_ck1_read: assert property (p_ck1_read) else $error("second status read wrong");

    property p_sys0_read;
        bus_req.rd && bus_req.addr == 8'h10 |=> rdata == {{(32-N0){1'h0}}, $past(pll0_sysclk_on)};
    endproperty
    a_sys0_read: assert property (p_sys0_read) else $error("first sysclk status wrong");

    property p_sys1_read;
        bus_req.rd && bus_req.addr == 8'h14 |=> rdata == {{(32-N1){1'h0}}, $past(pll1_sysclk_on)};
    endproperty
    a_sys1_read: assert property (p_sys1_read) else $error("second sysclk status wrong");
endmodule

`default_nettype wire

// [verification/pcs_clock_status_bench.sv]
/*
 Self-checking bench for the clock status block and profiling counter.
 Assumes the design files and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_clock_status_bench;
    import pcs_pkg::*;

    // One bus step: write flag, offset, data or expected read
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
    } pcs_row_t;

    logic          sys_clk;     // 50 MHz clock
    logic          arst_n;      // Reset pin
    pcs_bus_req_t  bus_req;     // Request bundle
    logic [31:0]   rdata;       // Read data
    logic          obs0;        // First observe gate
    logic          aux0;        // Aux gate
    logic          obs1;        // Second observe gate
    logic [6:0]    sys0;        // First sysclk gates
    logic [2:0]    sys1;        // Second sysclk gates
    int            fails;       // Mismatch count
    int            total_checks; // Compare count
    int            cycles;      // Hang guard
    logic [31:0]   q, prev, cur; // Read results

    // Reset state, then writes, each but the 8'h04 clear followed by reads that see them
    pcs_row_t rows [24] = '{
        '{1'h0, 8'h04, 32'h0}, '{1'h0, 8'h08, 32'h3}, '{1'h0, 8'h0C, 32'h0},
        '{1'h0, 8'h10, 32'h7F}, '{1'h0, 8'h14, 32'h7}, '{1'h0, 8'h00, 32'h3},
        '{1'h1, 8'h04, 32'hFFFFFFFF}, '{1'h0, 8'h04, 32'h2}, '{1'h0, 8'h0C, 32'h2},
        '{1'h1, 8'h1C, 32'h0}, '{1'h0, 8'h0C, 32'h0}, '{1'h1, 8'h04, 32'h0},
        '{1'h1, 8'h00, 32'h1}, '{1'h0, 8'h08, 32'h1}, '{1'h1, 8'h00, 32'h2},
        '{1'h1, 8'h18, 32'h0}, '{1'h0, 8'h08, 32'h0}, '{1'h1, 8'h20, 32'h0},
        '{1'h0, 8'h10, 32'h0}, '{1'h1, 8'h14, 32'hFFFFFFFF}, '{1'h0, 8'h14, 32'h7},
        '{1'h0, 8'h30, 32'h0}, '{1'h0, 8'h28, 32'h0}, '{1'h0, 8'h2C, 32'h0}};

    pcs_clock_status pcs_clock_status_i (
        .sys_clk               (sys_clk),
        .arst_n                (arst_n),
        .bus_req               (bus_req),
        .rdata                 (rdata),
        .pll0_observe_clock_on (obs0),
        .pll0_aux_clock_on     (aux0),
        .pll1_observe_clock_on (obs1),
        .pll0_sysclk_on        (sys0),
        .pll1_sysclk_on        (sys1)
    );

    // Free-running clock
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Single verdict point for normal end and hang
    task automatic report_and_stop();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            fails++;
        end
    endtask

    // Two cycles per access; idle cycle keeps strobes one cycle long
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        bus_req <= '{a, d, w, ~w};
        @(posedge sys_clk);
        bus_req <= '0;
        @(posedge sys_clk);
        r = rdata;
    endtask

    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        arst_n = 1'h0;
        bus_req = '0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        // Table of register cases
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].a, rows[i].w ? rows[i].d : 32'h0, q);
            if (!rows[i].w) chk($sformatf("row %0d", i), q, rows[i].d);
        end
        $display("register table done");
        // Counter: start, then low reads exactly 40 clocks apart
        xfer(1'h1, 8'h28, 32'hFFFFFFFF, q);
        xfer(1'h0, 8'h28, 32'h0, prev);
        for (int i = 0; i < 4; i++) begin
            // Filler: high read, restart write, read-only write, high read
            xfer(i == 1 || i == 2, i == 1 ? 8'h28 : 8'h2C, 32'hFFFFFFFF, q);
            if (i == 0 || i == 3) chk("high word", q, 32'h0);
            repeat (36) @(posedge sys_clk);
            xfer(1'h0, 8'h28, 32'h0, cur);
            if (i == 0) chk("start value", cur >> 4, 32'h0);
            if (i > 0) chk("step", cur - prev, 32'hA);
            prev = cur;
        end
        $display("counter done");
        // Second reset: enables restored, counter stopped
        arst_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        xfer(1'h0, 8'h08, 32'h0, q);
        chk("status after reset", q, 32'h3);
        xfer(1'h0, 8'h28, 32'h0, q);
        repeat (38) @(posedge sys_clk);
        xfer(1'h0, 8'h28, 32'h0, q);
        chk("count after reset", q, 32'h0);
        $display("reset done");
        report_and_stop();
    end
endmodule

bind pcs_clock_status pcs_chk #(.N0(N0), .N1(N1)) pcs_chk_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
    .pll0_observe_clock_on(pll0_observe_clock_on), .pll0_aux_clock_on(pll0_aux_clock_on),
    .pll1_observe_clock_on(pll1_observe_clock_on), .pll0_sysclk_on(pll0_sysclk_on),
    .pll1_sysclk_on(pll1_sysclk_on));

`default_nettype wire
